// ---- design/aqaz_pkg.sv ----
// Functional notes
// - Masked write of one to the auto-zero bit starts the offset calibration.
// - Done flag rises after 3352 rising edges of the slow die-link clock.
// - Writing one to the done flag clears it.
// - On completion the four 11-bit per-gain offset results are updated and readable.
// - Each voltage channel holds hot and cold trim deltas, read as signed values.
package aqaz_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_VPIN = 8'h4B;
  localparam logic [7:0] IDX_TPIN = 8'h4C;
  localparam logic [7:0] IDX_ACQUISITION_CONTROL = 8'h58;
  localparam logic [7:0] IDX_ACQ_STAT = 8'h5A;
  localparam logic [7:0] IDX_CHAIN_UP = 8'h5C;
  localparam logic [7:0] IDX_CHAIN_LO = 8'h5E;
  localparam logic [7:0] IDX_DEC = 8'h60;
  localparam logic [7:0] IDX_BGC = 8'h61;
  localparam logic [7:0] IDX_GAIN = 8'h62;
  localparam logic [7:0] IDX_GTHR = 8'h63;
  localparam logic [7:0] IDX_ITEMP = 8'h64;
  localparam logic [7:0] IDX_ETEMP = 8'h66;
  localparam logic [7:0] IDX_CURR_UP = 8'h68;
  localparam logic [7:0] IDX_CURR_LO = 8'h6A;
  localparam logic [7:0] IDX_VOLT = 8'h6C;
  localparam logic [7:0] IDX_LPFC = 8'h6E;
  localparam logic [7:0] IDX_COMP = 8'hA0;
  localparam logic [7:0] IDX_AZRES0 = 8'hA2;
  localparam logic [7:0] IDX_TRIM0 = 8'hA8;
  // Field layout
  localparam int MASK_SHIFT = 8;
  localparam int COMP_AZ_BIT = 0;
  localparam int COMP_DONE_BIT = 7;
  localparam int COLD_SHIFT = 8;
  localparam logic [7:0] TPIN_VMASK = 8'h1F;
  localparam logic [7:0] ACQUISITION_CONTROL_VMASK = 8'hBF;
  localparam logic [7:0] CHAIN_LO_VMASK = 8'h80;
  localparam logic [7:0] GAIN_VMASK = 8'hFE;
  localparam logic [7:0] DEC_VMASK = 8'h07;
  localparam logic [7:0] LPFC_VMASK = 8'h0F;
  localparam logic [7:0] COMP_VMASK = 8'h01;
  localparam int NUM_GAINS = 4;
  localparam int AZ_RES_W = 11;
  localparam int NUM_VCHAN = 5;
  localparam int TRIM_W = 5;
  localparam int CURR_W = 24;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  // AHB encodings
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  // Auto-zero timing, counted on the slow die-link clock
  localparam int AZ_SLOW_CLK_KHZ = 512;
  localparam int AZ_SLOW_CYCLES = 3352;
  localparam int AZ_TIME_US_NOMINAL = (AZ_SLOW_CYCLES * 1000) / AZ_SLOW_CLK_KHZ;
  // Sequencer states
  typedef enum logic [2:0] {
    AQAZ_IDLE = 3'b001,
    AQAZ_RUN = 3'b010,
    AQAZ_HOLD = 3'b100
  } aqaz_seq_state_type;
endpackage

// ---- design/aqaz_seq.sv ----
`timescale 1ns/1ps
module aqaz_seq
  import aqaz_pkg::*;
#(
  parameter int CYCLES = AZ_SLOW_CYCLES
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic die_link_slow_clock,
  input wire logic autozero_request,
  output logic running,
  output logic done_pulse
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  aqaz_seq_state_type state_q;
  logic [CNT_W-1:0] cnt_q;
  logic slow_q;
  logic tick;

  // Slow clock is synchronous to hclk, so a plain edge detect suffices
  assign tick = die_link_slow_clock & ~slow_q;
  assign running = (state_q == AQAZ_RUN);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      slow_q <= 1'b0;
    else if (ce)
      slow_q <= die_link_slow_clock;
  end

  // Run while requested; hold after done until software drops the request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= AQAZ_IDLE;
      cnt_q <= CNT_ZERO;
      done_pulse <= 1'b0;
    end
    else if (ce)
    begin
      done_pulse <= 1'b0;
      unique case (state_q)
        AQAZ_IDLE:
        begin
          cnt_q <= CNT_ZERO;
          if (autozero_request)
            state_q <= AQAZ_RUN;
        end
        AQAZ_RUN:
        begin
          if (!autozero_request)
            state_q <= AQAZ_IDLE;
          else if (tick && cnt_q == CNT_LAST)
          begin
            state_q <= AQAZ_HOLD;
            done_pulse <= 1'b1;
          end
          else if (tick)
            cnt_q <= cnt_q + 1'b1;
        end
        AQAZ_HOLD:
        begin
          cnt_q <= CNT_ZERO;
          if (!autozero_request)
            state_q <= AQAZ_IDLE;
        end
        default:
          state_q <= AQAZ_IDLE;
      endcase
    end
  end
endmodule // aqaz_seq

// ---- design/aqaz_ctrl.sv ----
`timescale 1ns/1ps
module aqaz_ctrl
  import aqaz_pkg::*;
#(
  parameter int AZ_CYCLES = AZ_SLOW_CYCLES
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  input wire logic die_link_slow_clock,
  input wire logic [7:0] meas_event,
  input wire logic [4:0] meas_level,
  input wire logic [15:0] itemp_in,
  input wire logic [15:0] etemp_in,
  input wire logic [23:0] current_in,
  input wire logic [15:0] voltage_in,
  input wire logic [43:0] fe_offset_code,
  output logic [7:0] vsense_pin_cfg,
  output logic [7:0] tsense_pin_cfg,
  output logic [7:0] acq_enable,
  output logic [7:0] chain_enable,
  output logic chain_zero,
  output logic [2:0] decimation_select,
  output logic [7:0] gain_cfg,
  output logic [7:0] gain_threshold,
  output logic [3:0] filter_count,
  output logic autozero_run
);
  // Masked byte update: only bits whose mask bit is one take new data
  function automatic logic [7:0] masked_upd(input logic [7:0] cur, input logic [15:0] wd,
                                            input logic [7:0] vmask);
    logic [7:0] m;
    m = wd[15:8] & vmask;
    masked_upd = (cur & ~m) | (wd[7:0] & m);
  endfunction

  function automatic logic [7:0] sext5(input logic [TRIM_W-1:0] v);
    sext5 = {{(8-TRIM_W){v[TRIM_W-1]}}, v};
  endfunction

  logic pend_q;
  logic pend_wr_q;
  logic [7:0] pend_idx_q;
  logic accept;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [31:0] rd_mux;
  logic [7:0] vpin_q;
  logic [7:0] tpin_q;
  logic [7:0] acquisition_control_q;
  logic [7:0] stat_flags_q;
  logic [7:0] chain_up_q;
  logic [7:0] chain_lo_q;
  logic [7:0] dec_q;
  logic [7:0] gain_q;
  logic [7:0] gthr_q;
  logic [7:0] lpfc_q;
  logic [7:0] comp_q;
  logic done_flag_q;
  logic [AZ_RES_W-1:0] az_res_q [NUM_GAINS];
  logic [TRIM_W-1:0] trim_hot_q [NUM_VCHAN];
  logic [TRIM_W-1:0] trim_cold_q [NUM_VCHAN];
  logic [15:0] itemp_q;
  logic [15:0] etemp_q;
  logic [CURR_W-1:0] curr_q;
  logic [15:0] volt_q;
  logic seq_running;
  logic seq_done;

  // One wait state on every transfer so reads always see prior writes
  assign accept = hsel & htrans[HTRANS_ACTIVE_BIT] & hready & hreadyout;
  assign wr_en = pend_q & pend_wr_q;
  assign wr_idx = pend_idx_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_q <= 1'b0;
      pend_wr_q <= 1'b0;
      pend_idx_q <= RST_BYTE;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      hrdata <= RST_WORD;
    end
    else if (ce)
    begin
      hresp <= HRESP_OKAY;
      if (accept)
      begin
        pend_q <= 1'b1;
        pend_wr_q <= hwrite;
        pend_idx_q <= haddr[9:2];
        hreadyout <= 1'b0;
      end
      else if (pend_q)
      begin
        pend_q <= 1'b0;
        hreadyout <= 1'b1;
        if (!pend_wr_q)
          hrdata <= rd_mux;
      end
    end
  end

  // Pin configuration and plain control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vpin_q <= RST_BYTE;
      tpin_q <= RST_BYTE;
      dec_q <= RST_BYTE;
      gain_q <= RST_BYTE;
      gthr_q <= RST_BYTE;
      lpfc_q <= RST_BYTE;
    end
    else if (ce && wr_en)
    begin
      if (wr_idx == IDX_VPIN)
        vpin_q <= hwdata[7:0];
      if (wr_idx == IDX_TPIN)
        tpin_q <= hwdata[7:0] & TPIN_VMASK;
      if (wr_idx == IDX_DEC)
        dec_q <= hwdata[7:0] & DEC_VMASK;
      if (wr_idx == IDX_GAIN)
        gain_q <= hwdata[7:0] & GAIN_VMASK;
      if (wr_idx == IDX_GTHR)
        gthr_q <= hwdata[7:0];
      if (wr_idx == IDX_LPFC)
        lpfc_q <= hwdata[7:0] & LPFC_VMASK;
    end
  end

  // Masked control registers: upper byte is the write mask
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acquisition_control_q <= RST_BYTE;
      chain_up_q <= RST_BYTE;
      chain_lo_q <= RST_BYTE;
      comp_q <= RST_BYTE;
    end
    else if (ce && wr_en)
    begin
      if (wr_idx == IDX_ACQUISITION_CONTROL)
        acquisition_control_q <= masked_upd(acquisition_control_q, hwdata[15:0], ACQUISITION_CONTROL_VMASK);
      if (wr_idx == IDX_CHAIN_UP)
        chain_up_q <= masked_upd(chain_up_q, hwdata[15:0], 8'hFF);
      if (wr_idx == IDX_CHAIN_LO)
        chain_lo_q <= masked_upd(chain_lo_q, hwdata[15:0], CHAIN_LO_VMASK);
      if (wr_idx == IDX_COMP)
        comp_q <= masked_upd(comp_q, hwdata[15:0], COMP_VMASK);
    end
  end

  // Acquisition event flags; a new event wins over a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stat_flags_q <= RST_BYTE;
    else if (ce)
    begin
      if (wr_en && wr_idx == IDX_ACQ_STAT)
        stat_flags_q <= (stat_flags_q & ~hwdata[15:8]) | meas_event;
      else
        stat_flags_q <= stat_flags_q | meas_event;
    end
  end

  // Done flag: set by the sequencer, write one clears, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      done_flag_q <= 1'b0;
    else if (ce)
    begin
      if (seq_done)
        done_flag_q <= 1'b1;
      else if (wr_en && wr_idx == IDX_COMP && hwdata[COMP_DONE_BIT])
        done_flag_q <= 1'b0;
    end
  end

  // Per-gain offset results are captured from the front end at completion
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int g = 0; g < NUM_GAINS; g++)
        az_res_q[g] <= '0;
    end
    else if (ce && seq_done)
    begin
      for (int g = 0; g < NUM_GAINS; g++)
        az_res_q[g] <= fe_offset_code[g*AZ_RES_W +: AZ_RES_W];
    end
  end

  // Trim deltas per voltage channel, hot in low field, cold in upper field
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < NUM_VCHAN; c++)
      begin
        trim_hot_q[c] <= '0;
        trim_cold_q[c] <= '0;
      end
    end
    else if (ce && wr_en)
    begin
      for (int c = 0; c < NUM_VCHAN; c++)
      begin
        if (wr_idx == IDX_TRIM0 + 8'(c))
        begin
          trim_hot_q[c] <= hwdata[TRIM_W-1:0];
          trim_cold_q[c] <= hwdata[COLD_SHIFT +: TRIM_W];
        end
      end
    end
  end

  // Results sampled every enabled cycle so a read sees a coherent word
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      itemp_q <= '0;
      etemp_q <= '0;
      curr_q <= '0;
      volt_q <= '0;
    end
    else if (ce)
    begin
      itemp_q <= itemp_in;
      etemp_q <= etemp_in;
      curr_q <= current_in;
      volt_q <= voltage_in;
    end
  end

  // Read mux; unmapped and reserved locations read as zero
  always_comb
  begin
    rd_mux = RST_WORD;
    unique case (pend_idx_q)
      IDX_VPIN: rd_mux[7:0] = vpin_q;
      IDX_TPIN: rd_mux[7:0] = tpin_q;
      IDX_ACQUISITION_CONTROL: rd_mux[7:0] = acquisition_control_q;
      IDX_ACQ_STAT: rd_mux[15:0] = {stat_flags_q, 3'b000, meas_level};
      IDX_CHAIN_UP: rd_mux[7:0] = chain_up_q;
      IDX_CHAIN_LO: rd_mux[7:0] = chain_lo_q;
      IDX_DEC: rd_mux[7:0] = dec_q;
      IDX_BGC: rd_mux = RST_WORD;
      IDX_GAIN: rd_mux[7:0] = gain_q;
      IDX_GTHR: rd_mux[7:0] = gthr_q;
      IDX_ITEMP: rd_mux[15:0] = itemp_q;
      IDX_ETEMP: rd_mux[15:0] = etemp_q;
      IDX_CURR_UP: rd_mux[7:0] = curr_q[23:16];
      IDX_CURR_LO: rd_mux[15:0] = curr_q[15:0];
      IDX_VOLT: rd_mux[15:0] = volt_q;
      IDX_LPFC: rd_mux[7:0] = lpfc_q;
      IDX_COMP:
      begin
        rd_mux[COMP_AZ_BIT] = comp_q[COMP_AZ_BIT];
        rd_mux[COMP_DONE_BIT] = done_flag_q;
      end
      default:
      begin
        for (int g = 0; g < NUM_GAINS; g++)
          if (pend_idx_q == IDX_AZRES0 + 8'(g))
            rd_mux[AZ_RES_W-1:0] = az_res_q[g];
        for (int c = 0; c < NUM_VCHAN; c++)
          if (pend_idx_q == IDX_TRIM0 + 8'(c))
            rd_mux[15:0] = {sext5(trim_cold_q[c]), sext5(trim_hot_q[c])};
      end
    endcase
  end

  // Outputs to the analog front end, all from flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vsense_pin_cfg <= RST_BYTE;
      tsense_pin_cfg <= RST_BYTE;
      acq_enable <= RST_BYTE;
      chain_enable <= RST_BYTE;
      chain_zero <= 1'b0;
      decimation_select <= '0;
      gain_cfg <= RST_BYTE;
      gain_threshold <= RST_BYTE;
      filter_count <= '0;
      autozero_run <= 1'b0;
    end
    else if (ce)
    begin
      vsense_pin_cfg <= vpin_q;
      tsense_pin_cfg <= tpin_q;
      acq_enable <= acquisition_control_q;
      chain_enable <= chain_up_q;
      chain_zero <= chain_lo_q[7];
      decimation_select <= dec_q[2:0];
      gain_cfg <= gain_q;
      gain_threshold <= gthr_q;
      filter_count <= lpfc_q[3:0];
      autozero_run <= seq_running;
    end
  end

  // Calibration timer on the slow die-link clock
  aqaz_seq #(
    .CYCLES(AZ_CYCLES)
  ) u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .die_link_slow_clock(die_link_slow_clock),
    .autozero_request(comp_q[COMP_AZ_BIT]),
    .running(seq_running),
    .done_pulse(seq_done)
  );

  logic unused_ok;
  assign unused_ok = ^{haddr[31:10], haddr[1:0], hsize, hwdata[31:16], htrans[0]};
endmodule // aqaz_ctrl

// ---- verif/aqaz_ctrl_checker.sv ----
`timescale 1ns/1ps
module aqaz_chk
  import aqaz_pkg::*;
#(
  parameter int AZ_CYCLES = AZ_SLOW_CYCLES
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  input wire logic die_link_slow_clock,
  input wire logic [7:0] acq_enable,
  input wire logic [7:0] gain_cfg,
  input wire logic autozero_run
);
  logic acc;
  logic aw_q;
  logic [7:0] ai_q;
  logic slow_q;
  logic edge_q;
  int cnt_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign acc = hsel && htrans[1] && hready && hreadyout && ce;
  // Remember the accepted write so its data phase can be judged
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aw_q <= 1'b0;
      ai_q <= 8'h00;
    end
    else if (ce)
    begin
      aw_q <= acc && hwrite;
      ai_q <= haddr[9:2];
    end
  end
  // Slow edges delayed one cycle, matching the run flag's lag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slow_q <= 1'b0;
      edge_q <= 1'b0;
      cnt_q <= 0;
    end
    else if (ce)
    begin
      slow_q <= die_link_slow_clock;
      edge_q <= die_link_slow_clock && !slow_q;
      cnt_q <= autozero_run ? cnt_q + int'(edge_q) : 0;
    end
  end
  sequence s_data;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_comp_wr;
    aw_q && ai_q == IDX_COMP && hwdata[8];
  endsequence
  AST_READY: assert property (acc |=> s_data)
    else $error("data phase not two cycles");
  AST_OKAY: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  AST_AZ_START: assert property (s_comp_wr ##0 (hwdata[0] && !autozero_run) |-> ##[1:4] autozero_run)
    else $error("auto-zero did not start");
  AST_AZ_STOP: assert property (s_comp_wr ##0 !hwdata[0] |-> ##[1:4] !autozero_run)
    else $error("auto-zero did not stop");
  AST_AZ_COUNT: assert property (cnt_q <= AZ_CYCLES)
    else $error("calibration ran past its count");
  AST_AZ_END: assert property (cnt_q == AZ_CYCLES |-> ##[0:2] !autozero_run)
    else $error("calibration did not end on count");
  AST_RUN_STEADY: assert property ($rose(autozero_run) |-> autozero_run[*8])
    else $error("calibration ended too soon");
  AST_GAIN_WR: assert property ($changed(gain_cfg) |-> $past(aw_q && ai_q == IDX_GAIN, 2))
    else $error("gain changed without a write");
  AST_ACQ_MASK: assert property ($changed(acq_enable) |->
    $past(aw_q && ai_q == IDX_ACQUISITION_CONTROL && hwdata[15:8] != 8'h00, 2))
    else $error("control changed without mask");
endmodule // aqaz_chk

bind aqaz_ctrl aqaz_chk #(.AZ_CYCLES(AZ_CYCLES)) aqaz_chk_inst (.hclk(hclk), .hresetn(hresetn),
  .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .die_link_slow_clock(die_link_slow_clock), .acq_enable(acq_enable), .gain_cfg(gain_cfg),
  .autozero_run(autozero_run));

// ---- verif/aqaz_ctrl_tb.sv ----
`timescale 1ns/1ps
module aqaz_ctrl_tb;
  import aqaz_pkg::*;
  localparam int AZN = 4;
  logic hclk = 0;
  logic hresetn = 0;
  logic ce = 1;
  logic hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 0;
  logic die_link_slow_clock = 0;
  logic [7:0] meas_event = 0;
  logic [4:0] meas_level = 0;
  logic [15:0] itemp_in = 0;
  logic [15:0] etemp_in = 0;
  logic [23:0] current_in = 0;
  logic [15:0] voltage_in = 0;
  int sdiv = 0;
  logic [43:0] fe_offset_code = 0;
  logic [43:0] fe_old;
  wire hready;
  wire [31:0] hrdata;
  wire [7:0] acq_enable;
  wire [7:0] gain_cfg;
  wire autozero_run;
  wire [7:0] vsp;
  wire [7:0] tsp;
  wire [7:0] cen;
  wire [7:0] gthr;
  wire czero;
  wire [3:0] fcnt;
  wire [2:0] dsel;
  int n_errors = 0;
  int n_tests = 0;
  int n_slow = 0;
  int t0;
  logic [31:0] rd;
  logic [7:0] m;
  logic [7:0] v;
  logic [7:0] acq = 0;
  logic [7:0] cup = 0;
  logic [7:0] clo = 0;
  logic [4:0] h;
  logic [4:0] c;
  logic [7:0] ridx[8] = '{IDX_VPIN, IDX_ACQUISITION_CONTROL, IDX_GAIN, IDX_DEC, IDX_COMP, IDX_AZRES0,
    IDX_BGC, 8'hFF};
  aqaz_ctrl #(.AZ_CYCLES(AZN)) aqaz_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(), .hrdata(hrdata),
    .die_link_slow_clock(die_link_slow_clock), .meas_event(meas_event),
    .meas_level(meas_level), .itemp_in(itemp_in), .etemp_in(etemp_in),
    .current_in(current_in), .voltage_in(voltage_in), .fe_offset_code(fe_offset_code),
    .vsense_pin_cfg(vsp), .tsense_pin_cfg(tsp), .acq_enable(acq_enable), .chain_enable(cen),
    .chain_zero(czero), .decimation_select(dsel), .gain_cfg(gain_cfg), .gain_threshold(gthr),
    .filter_count(fcnt), .autozero_run(autozero_run));
  // Bus clock 200 MHz; slow clock near 512 kHz, free running
  initial forever #2.5 hclk = ~hclk;
  // Slow clock toggled on hclk edges so it never races the design's sampling
  always @(posedge hclk)
  begin
    sdiv <= (sdiv == 194) ? 0 : sdiv + 1;
    if (sdiv == 194)
      die_link_slow_clock <= ~die_link_slow_clock;
  end
  always @(posedge die_link_slow_clock) n_slow++;
  task close_out;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One single transfer; waits on hready, no fixed latency assumed
  task bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rdc(input logic [7:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk(rd, e);
  endtask
  function automatic logic [31:0] sx(input logic [4:0] hh, input logic [4:0] cc);
    return {16'h0, {3{cc[4]}}, cc, {3{hh[4]}}, hh};
  endfunction
  // Main sequence
  initial
  begin
    void'($urandom(52));
    itemp_in <= 16'($urandom);
    etemp_in <= 16'($urandom);
    current_in <= 24'($urandom);
    voltage_in <= 16'($urandom);
    meas_level <= 5'($urandom);
    fe_offset_code <= {12'($urandom), 32'($urandom)};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ridx[k]) rdc(ridx[k], RST_WORD);
    for (int k = 0; k < 8; k++)
    begin
      m = (k == 0) ? 8'h00 : 8'($urandom);
      v = 8'($urandom);
      bus(1'b1, IDX_ACQUISITION_CONTROL, {16'h0, m, v});
      acq = ((acq & ~m) | (v & m)) & ACQUISITION_CONTROL_VMASK;
      rdc(IDX_ACQUISITION_CONTROL, {24'h0, acq});
      chk({24'h0, acq_enable}, {24'h0, acq});
      bus(1'b1, IDX_GAIN, {24'h0, v});
      rdc(IDX_GAIN, {24'h0, v & GAIN_VMASK});
      chk({24'h0, gain_cfg}, {24'h0, v & GAIN_VMASK});
    end
    bus(1'b1, IDX_ITEMP, $urandom);
    rdc(IDX_ITEMP, {16'h0, itemp_in});
    rdc(IDX_ETEMP, {16'h0, etemp_in});
    rdc(IDX_CURR_UP, {24'h0, current_in[23:16]});
    rdc(IDX_CURR_LO, {16'h0, current_in[15:0]});
    rdc(IDX_VOLT, {16'h0, voltage_in});
    // Plain and masked registers, read back and seen on their output pins
    for (int k = 0; k < 4; k++)
    begin
      v = 8'($urandom);
      m = 8'($urandom);
      bus(1'b1, IDX_VPIN, {24'h0, v});
      bus(1'b1, IDX_TPIN, {24'h0, v});
      bus(1'b1, IDX_DEC, {24'h0, v});
      bus(1'b1, IDX_GTHR, {24'h0, v});
      bus(1'b1, IDX_LPFC, {24'h0, v});
      bus(1'b1, IDX_CHAIN_UP, {16'h0, m, v});
      bus(1'b1, IDX_CHAIN_LO, {16'h0, m, v});
      cup = (cup & ~m) | (v & m);
      clo = ((clo & ~m) | (v & m)) & CHAIN_LO_VMASK;
      rdc(IDX_VPIN, {24'h0, v});
      rdc(IDX_TPIN, {24'h0, v & TPIN_VMASK});
      rdc(IDX_DEC, {24'h0, v & DEC_VMASK});
      rdc(IDX_GTHR, {24'h0, v});
      rdc(IDX_LPFC, {24'h0, v & LPFC_VMASK});
      rdc(IDX_CHAIN_UP, {24'h0, cup});
      rdc(IDX_CHAIN_LO, {24'h0, clo});
      chk({vsp, tsp, cen, gthr}, {v, v & TPIN_VMASK, cup, v});
      chk({24'h0, czero, fcnt, dsel}, {24'h0, clo[7], 4'(v & LPFC_VMASK), 3'(v & DEC_VMASK)});
    end
    @(posedge hclk) meas_event <= 8'hA5;
    @(posedge hclk) meas_event <= 8'h00;
    rdc(IDX_ACQ_STAT, {16'h0, 8'hA5, 3'h0, meas_level});
    bus(1'b1, IDX_ACQ_STAT, 32'h8100);
    rdc(IDX_ACQ_STAT, {16'h0, 8'h24, 3'h0, meas_level});
    for (int k = 0; k < NUM_VCHAN; k++)
    begin
      h = (k == 0) ? 5'h10 : 5'($urandom);
      c = (k == 0) ? 5'h0F : 5'($urandom);
      bus(1'b1, IDX_TRIM0 + 8'(k), {19'h0, c, 3'h0, h});
      rdc(IDX_TRIM0 + 8'(k), sx(h, c));
    end
    // Full calibration, then exit and clear
    // Start just after a slow falling edge so no rising edge slips past the count
    @(negedge die_link_slow_clock);
    t0 = n_slow;
    bus(1'b1, IDX_COMP, 32'h0101);
    do bus(1'b0, IDX_COMP, 32'h0); while (rd[COMP_DONE_BIT] !== 1'b1);
    chk(32'(n_slow - t0), AZN);
    chk(rd, 32'h81);
    chk({31'h0, autozero_run}, 32'h0);
    for (int g = 0; g < NUM_GAINS; g++)
      rdc(IDX_AZRES0 + 8'(g), {21'h0, fe_offset_code[g * 11 +: 11]});
    bus(1'b1, IDX_COMP, 32'h0100);
    rdc(IDX_COMP, 32'h80);
    bus(1'b1, IDX_COMP, 32'h80);
    rdc(IDX_COMP, 32'h0);
    // Aborted run must leave no flag and keep old results
    fe_old = fe_offset_code;
    fe_offset_code <= ~fe_old;
    bus(1'b1, IDX_COMP, 32'h0101);
    repeat (20) @(posedge hclk);
    chk({31'h0, autozero_run}, 32'h1);
    bus(1'b1, IDX_COMP, 32'h0100);
    repeat (2000) @(posedge hclk);
    rdc(IDX_COMP, 32'h0);
    rdc(IDX_AZRES0, {21'h0, fe_old[10:0]});
    // Reset while no calibration runs clears registers and outputs again
    @(posedge hclk) hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk({24'h0, gain_cfg}, RST_WORD);
    rdc(IDX_GAIN, RST_WORD);
    rdc(IDX_CHAIN_UP, RST_WORD);
    close_out;
  end
  // Hang guard, well beyond the expected run
  initial
  begin
    #100000;
    n_errors++;
    close_out;
  end
endmodule // aqaz_ctrl_tb
